// ===== verification/param_write_dev_model.sv
`timescale 1ns/1ps
// Far-side controller: takes offered words, stalling at random
module param_write_dev_model (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic ready_out
);
  // Ready drops about one cycle in three so held offers get exercised;
  // nothing is ever sent back, a write block has no answer words
  always @(posedge clk_in) begin
    if (rst_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= ($urandom % 3) != 0;
    end
  end
endmodule : param_write_dev_model

// ===== verification/param_write_formatter_sva.sv
`timescale 1ns/1ps
// Link and register-port checker for the formatter, sees only its ports
module pwf_check #(
  parameter int WORD_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rd_in,
  input wire logic [WORD_W-1:0] rd_data_out,
  input wire logic blk_ready_in,
  input wire logic blk_valid_out,
  input wire logic [WORD_W-1:0] blk_word_out,
  input wire param_write_pkg::word_pos_t blk_pos_out,
  input wire logic blk_last_out,
  input wire logic [11:0] blk_seq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Word handed over to the device in this cycle
  wire take = blk_valid_out && blk_ready_in;
  // Count word of the block in flight, so the last word can be placed
  logic [WORD_W-1:0] cnt_word;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_word <= '0;
    end else if (take && blk_pos_out == 3'h0) begin
      cnt_word <= blk_word_out;
    end
  end
  sequence s_take_mid;
    take && !blk_last_out;
  endsequence
  sequence s_gap_offer;
    !blk_valid_out ##1 blk_valid_out;
  endsequence
  a_offer_holds: assert property (blk_valid_out && !blk_ready_in |=> blk_valid_out &&
    $stable(blk_word_out) && $stable(blk_pos_out) && $stable(blk_seq_out))
    else $error("offer changed before take");
  a_next_offer: assert property (s_take_mid |=> s_gap_offer)
    else $error("next word not offered after one idle cycle");
  a_pos_steps: assert property (s_take_mid |-> ##2
    blk_pos_out == $past(blk_pos_out, 2) + 3'h1 && blk_seq_out == $past(blk_seq_out, 2))
    else $error("word offset did not step by one");
  a_count_fixed: assert property (blk_valid_out && blk_pos_out == 3'h0 |->
    blk_word_out == ((blk_seq_out inside {12'h053, 12'h054, 12'h055, 12'h059, 12'h062}) ?
    16'h0003 : (blk_seq_out == 12'h061) ? 16'h0005 : 16'h0004))
    else $error("count word wrong for sequence");
  a_unit_clean: assert property (blk_valid_out && blk_pos_out == 3'h1 |->
    blk_word_out[15:8] == 8'h00 && blk_word_out[7:0] <= 8'h31 && blk_word_out[3:0] <= 4'h9)
    else $error("unit word out of range");
  a_last_count: assert property (take && blk_last_out |->
    blk_pos_out == cnt_word[2:0] - 3'h1)
    else $error("last word not at count minus one");
  a_digits_bcd: assert property (blk_valid_out |-> blk_word_out[3:0] <= 4'h9 &&
    blk_word_out[7:4] <= 4'h9 && blk_word_out[11:8] <= 4'h9 && blk_word_out[15:12] <= 4'h9)
    else $error("non decimal digit sent");
  a_min_one: assert property (blk_valid_out && blk_pos_out >= 3'h2 &&
    blk_seq_out inside {12'h053, 12'h056, 12'h063} |-> blk_word_out != 16'h0000)
    else $error("zero sent where minimum is one");
  a_period_cap: assert property (blk_valid_out && blk_pos_out >= 3'h2 &&
    blk_seq_out == 12'h057 |-> blk_word_out inside {[16'h0001:16'h0099]})
    else $error("control period out of range");
  a_mv_cap: assert property (blk_valid_out && blk_pos_out inside {3'h2, 3'h3} &&
    blk_seq_out inside {12'h060, 12'h061} |-> blk_word_out <= 16'h1050)
    else $error("value above 1050 sent");
  a_rd_idle: assert property (!rd_in |=> rd_data_out == '0)
    else $error("read data outside read answer cycle");
endmodule : pwf_check

bind param_write_formatter pwf_check #(.WORD_W(WORD_W)) u_check (.clk_in(clk_in),
  .rst_in(rst_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .blk_ready_in(blk_ready_in),
  .blk_valid_out(blk_valid_out), .blk_word_out(blk_word_out), .blk_pos_out(blk_pos_out),
  .blk_last_out(blk_last_out), .blk_seq_out(blk_seq_out));

// ===== verification/test_param_write_formatter.sv
`timescale 1ns/1ps
`include "param_write_params.svh"
module test_param_write_formatter;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rd_data_out;
  logic irq_out;
  logic blk_ready_in;
  logic blk_valid_out;
  logic [15:0] blk_word_out;
  param_write_pkg::word_pos_t blk_pos_out;
  logic blk_last_out;
  logic [11:0] blk_seq_out;
  logic rd_d = 1'b0; // Read strobe seen at the previous edge
  logic msk = 1'b1; // Interrupt mask used by the next block
  logic bad_unit = 1'b0; // Send unit 32 instead of a legal one
  logic [15:0] rq[$]; // Expected read data, oldest first
  logic [31:0] lq[$]; // Expected link words: offset, last, sequence, word
  int n_mismatch = 0;
  int compares = 0;
  // Clock, 50 ns period
  always #25 clk_in = ~clk_in;
  param_write_formatter uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .irq_out(irq_out), .blk_ready_in(blk_ready_in), .blk_valid_out(blk_valid_out),
    .blk_word_out(blk_word_out), .blk_pos_out(blk_pos_out), .blk_last_out(blk_last_out),
    .blk_seq_out(blk_seq_out));
  param_write_dev_model dev (.clk_in(clk_in), .rst_in(rst_in), .ready_out(blk_ready_in));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Watcher: read answers and taken words against the oldest note
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    if (rd_d === 1'b1) begin
      check("read data", {16'h0000, rq.pop_front()}, {16'h0000, rd_data_out});
    end
    if (blk_valid_out === 1'b1 && blk_ready_in === 1'b1) begin
      check("link word", lq.pop_front(), {blk_pos_out, blk_last_out, blk_seq_out, blk_word_out});
    end
  end
  // One bus cycle; strobes stay up until the next call or idle
  task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wr_data_in <= d;
    if (!w) rq.push_back(d);
    @(posedge clk_in);
  endtask : acc
  task automatic idle();
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask : idle
  // Random four-digit decimal value
  function automatic logic [15:0] rbcd();
    return {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
  endfunction : rbcd
  // Load one block, start it, await the interrupt and settle the status
  task automatic blk(logic [11:0] seq, logic [15:0] cnt, logic ok, logic [15:0] p0,
    logic [15:0] p1 = 16'h0000, logic [15:0] p2 = 16'h0000, logic hc = 1'b0);
    logic [15:0] unit;
    logic [15:0] w[5];
    int d;
    int n;
    logic sq_bad; // Sequence outside the supported set
    logic cn_bad; // Count differs from the fixed figure
    logic bc_bad; // Non-decimal digit or unit above 31
    logic [15:0] fixed_cnt; // Word count the sequence demands
    logic [15:0] cause; // Expected error cause word
    d = $urandom % 32;
    sq_bad = !(seq inside {[12'h053:12'h059], [12'h060:12'h063]});
    fixed_cnt = (seq inside {12'h053, 12'h054, 12'h055, 12'h059, 12'h062}) ? 16'h0003 :
      (seq == 12'h061) ? 16'h0005 : 16'h0004;
    cn_bad = sq_bad || (cnt != fixed_cnt);
    bc_bad = bad_unit || (p0[3:0] > 4'h9) || (p0[7:4] > 4'h9) || (p0[11:8] > 4'h9) ||
      (p0[15:12] > 4'h9);
    // An unknown sequence has no legal values, so it also reads as out of range
    cause = ok ? 16'h0000 : {12'h000, !bc_bad && (sq_bad || !cn_bad), bc_bad, cn_bad, sq_bad};
    unit = bad_unit ? 16'h0032 : {8'($urandom), 4'(d / 10), 4'(d % 10)};
    w = '{cnt, {8'h00, unit[7:0]}, p0, p1, p2};
    acc(1'b1, `REG_MASK, {14'h0000, msk, msk});
    for (int i = 1; i < 6; i++) acc(1'b1, 4'(i), i == 2 ? unit : w[i - 1]);
    if (ok) for (int i = 0; i < cnt; i++) lq.push_back({3'(i), 1'(i == cnt - 1), seq, w[i]});
    acc(1'b1, `REG_CTRL, {1'b1, 2'b00, hc, seq});
    // Overwrite while busy must not reach the wire
    if (ok) acc(1'b1, `REG_PARAM0, ~p0);
    idle();
    for (n = 0; n < 200 && irq_out !== 1'b1; n++) @(posedge clk_in);
    check("irq raised", {31'h0, msk}, {31'h0, irq_out});
    acc(1'b0, `REG_STATUS, ok ? 16'h0001 : 16'h0002);
    acc(1'b0, `REG_ERROR, cause);
    acc(1'b0, `REG_PARAM0, p0);
    acc(1'b0, `REG_UNIT, {8'h00, unit[7:0]});
    acc(1'b0, `REG_CTRL, {3'b000, hc, seq});
    acc(1'b1, `REG_STATUS, 16'h0003);
    idle();
    repeat (2) @(posedge clk_in);
    check("irq cleared", 32'h0, {31'h0, irq_out});
  endtask : blk
  task automatic final_report();
    if (lq.size() != 0) check("link words left", 32'h0, 32'(lq.size()));
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Main sequence: reset values, then every sequence at its edges
  initial begin
    void'($urandom(32'h3f99));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    acc(1'b0, `REG_STATUS, 16'h0000);
    acc(1'b0, 4'hf, 16'h0000);
    acc(1'b1, `REG_MASK, 16'h0003);
    acc(1'b0, `REG_MASK, 16'h0003);
    idle();
    blk(12'h053, 16'h0003, 1'b1, 16'h0001);
    blk(12'h053, 16'h0003, 1'b0, 16'h0000);
    blk(12'h053, 16'h0004, 1'b0, 16'h9999);
    blk(12'h054, 16'h0003, 1'b1, rbcd());
    blk(12'h055, 16'h0003, 1'b1, 16'h1000);
    blk(12'h055, 16'h0003, 1'b0, 16'h1001);
    blk(12'h056, 16'h0004, 1'b1, 16'h0001, 16'h9999);
    blk(12'h056, 16'h0004, 1'b0, 16'h9999, 16'h0000);
    blk(12'h057, 16'h0004, 1'b1, 16'h0099, 16'h0001);
    blk(12'h057, 16'h0004, 1'b0, 16'h0100, 16'h0001);
    blk(12'h058, 16'h0004, 1'b1, 16'h0001, rbcd());
    blk(12'h058, 16'h0004, 1'b1, 16'h0000, 16'h9999);
    blk(12'h058, 16'h0004, 1'b0, 16'h0002, 16'h0000);
    blk(12'h059, 16'h0003, 1'b1, rbcd());
    blk(12'h059, 16'h0003, 1'b0, 16'h00a0);
    blk(12'h060, 16'h0004, 1'b1, 16'h1050, 16'h0000);
    blk(12'h060, 16'h0004, 1'b0, 16'h0000, 16'h1051);
    blk(12'h061, 16'h0005, 1'b1, 16'h1050, 16'h1049, 16'h1000);
    blk(12'h061, 16'h0005, 1'b0, 16'h0500, 16'h0500, 16'h0000);
    blk(12'h061, 16'h0005, 1'b1, 16'h0500, 16'h0500, 16'h0000, 1'b1);
    blk(12'h061, 16'h0005, 1'b0, 16'h1000, 16'h0000, 16'h1001);
    blk(12'h061, 16'h0004, 1'b0, 16'h1000, 16'h0000);
    blk(12'h062, 16'h0003, 1'b1, 16'h9999);
    blk(12'h062, 16'h0004, 1'b0, 16'h0000);
    blk(12'h063, 16'h0004, 1'b1, 16'h0001, 16'h9999);
    blk(12'h063, 16'h0004, 1'b0, 16'h0001, 16'h0000);
    blk(12'h064, 16'h0003, 1'b0, 16'h0000);
    bad_unit = 1'b1;
    blk(12'h053, 16'h0003, 1'b0, 16'h0001);
    bad_unit = 1'b0;
    msk = 1'b0;
    blk(12'h054, 16'h0003, 1'b1, 16'h0000);
    msk = 1'b1;
    final_report();
  end
  // Watchdog: the whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    check("run finished", 32'h1, 32'h0);
    final_report();
  end
endmodule : test_param_write_formatter

// ===== verilog/param_write_formatter.sv
`timescale 1ns/1ps
`include "param_write_params.svh"
module param_write_formatter #(
  parameter int WORD_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [WORD_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [WORD_W-1:0] rd_data_out,
  output logic irq_out,
  input wire logic blk_ready_in,
  output logic blk_valid_out,
  output logic [WORD_W-1:0] blk_word_out,
  output param_write_pkg::word_pos_t blk_pos_out,
  output logic blk_last_out,
  output logic [11:0] blk_seq_out
);

  // Every check below looks at the latched block only; nothing is judged
  // while software is still filling the registers, so a half-written block
  // can never slip through.
  // Four BCD digits, each 0 to 9
  function automatic logic is_bcd4(input logic [15:0] w);
    is_bcd4 = (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) &&
              (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
  endfunction : is_bcd4

  // Inclusive range test; valid BCD orders like binary
  function automatic logic in_range(input logic [15:0] w, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (w >= lo) && (w <= hi);
  endfunction : in_range

  // Fixed word count of each supported sequence, zero when unsupported;
  // zero is a safe marker, since no block may legally be empty
  function automatic logic [15:0] seq_count(input logic [11:0] s);
    case (s)
      `SEQ_COOL_COEF, `SEQ_DEAD_BAND, `SEQ_MAN_RESET, `SEQ_LOOP_BREAK,
      `SEQ_DIG_FILTER: seq_count = `COUNT_ONE_PARAM;
      `SEQ_HYSTERESIS, `SEQ_CTRL_PERIOD, `SEQ_RAMP, `SEQ_MV_STOP_ERR,
      `SEQ_ALARM_HYST: seq_count = `COUNT_TWO_PARAM;
      `SEQ_MV_LIMITS: seq_count = `COUNT_THREE_PARAM;
      default: seq_count = `RST_WORD;
    endcase
  endfunction : seq_count

  // Software-visible settings
  // Sequence, option, count, unit and parameters are frozen while busy, so a check and its send see one block
  logic [11:0] seq; // Sequence number to issue
  logic heat_cool; // Heating/cooling control option for limits
  logic [15:0] count; // Word count supplied by software
  logic [7:0] unit; // Target unit number, low byte only
  logic [15:0] param [3]; // Parameter words +2 to +4
  logic [2:0] status; // Sticky done and error, live busy
  logic [2:0] mask; // Interrupt enables, same layout as status
  logic [3:0] err_cause; // Reason the last check failed, zero if it passed

  // Sequencer state
  // Position walks 0 to last_pos; three bits cover the longest block of five
  param_write_pkg::fmt_state_t state;
  param_write_pkg::fmt_state_t next_state;
  param_write_pkg::word_pos_t pos; // Word being offered to the device
  logic [2:0] last_pos; // Final word position of this block

  // Register port decode
  // Decodes are plain wires so the clocked blocks stay short
  wire wr_ctrl = wr_in && (addr_in == `REG_CTRL);
  wire wr_count = wr_in && (addr_in == `REG_COUNT);
  wire wr_unit = wr_in && (addr_in == `REG_UNIT);
  wire wr_status = wr_in && (addr_in == `REG_STATUS);
  wire wr_mask = wr_in && (addr_in == `REG_MASK);
  wire go = wr_ctrl && wr_data_in[`CTRL_GO_BIT];
  wire busy = (state != param_write_pkg::ST_IDLE);

  // Field checks on the latched block
  wire [15:0] p0 = param[0];
  wire [15:0] p1 = param[1];
  wire [15:0] p2 = param[2];
  wire [15:0] want_count = seq_count(seq);
  wire seq_ok = (want_count != `RST_WORD);
  // Count must match the fixed figure of the sequence
  wire count_ok = seq_ok && (count == want_count);
  wire two_used = (want_count != `COUNT_ONE_PARAM);
  wire three_used = (want_count == `COUNT_THREE_PARAM);
  // Unit is two BCD digits 00 to 31; unused upper byte plays no part
  wire unit_ok = (unit[3:0] <= 4'h9) && (unit <= `LIM_UNIT_MAX);
  wire bcd_ok = is_bcd4(count) && is_bcd4(p0) && (!two_used || is_bcd4(p1)) &&
                (!three_used || is_bcd4(p2));

  // One-parameter sequences
  wire ok_053 = in_range(p0, `LIM_MIN_ONE, `LIM_MAX_ALL);
  wire ok_054 = in_range(p0, `RST_WORD, `LIM_MAX_ALL);
  wire ok_055 = in_range(p0, `RST_WORD, `LIM_MAX_1000);
  wire ok_059 = in_range(p0, `RST_WORD, `LIM_MAX_ALL);
  wire ok_062 = in_range(p0, `RST_WORD, `LIM_MAX_ALL);
  // Two-parameter sequences
  wire ok_056 = in_range(p0, `LIM_MIN_ONE, `LIM_MAX_ALL) &&
                in_range(p1, `LIM_MIN_ONE, `LIM_MAX_ALL);
  wire ok_057 = in_range(p0, `LIM_MIN_ONE, `LIM_MAX_0099) &&
                in_range(p1, `LIM_MIN_ONE, `LIM_MAX_0099);
  wire ok_058 = in_range(p0, `RST_WORD, `LIM_RAMP_HOURS) &&
                in_range(p1, `RST_WORD, `LIM_MAX_ALL);
  wire ok_060 = in_range(p0, `RST_WORD, `LIM_MAX_1050) &&
                in_range(p1, `RST_WORD, `LIM_MAX_1050);
  wire ok_063 = in_range(p0, `LIM_MIN_ONE, `LIM_MAX_ALL) &&
                in_range(p1, `LIM_MIN_ONE, `LIM_MAX_ALL);
  // Limits: in heating/cooling mode the order test is dropped
  wire lim_order = heat_cool || (p1 < p0);
  wire ok_061 = in_range(p0, `RST_WORD, `LIM_MAX_1050) &&
                in_range(p1, `RST_WORD, `LIM_MAX_1050) && lim_order &&
                in_range(p2, `RST_WORD, `LIM_MAX_1000);

  // Range result of the selected sequence
  logic range_ok;
  always_comb begin
    case (seq)
      `SEQ_COOL_COEF: range_ok = ok_053;
      `SEQ_DEAD_BAND: range_ok = ok_054;
      `SEQ_MAN_RESET: range_ok = ok_055;
      `SEQ_HYSTERESIS: range_ok = ok_056;
      `SEQ_CTRL_PERIOD: range_ok = ok_057;
      `SEQ_RAMP: range_ok = ok_058;
      `SEQ_LOOP_BREAK: range_ok = ok_059;
      `SEQ_MV_STOP_ERR: range_ok = ok_060;
      `SEQ_MV_LIMITS: range_ok = ok_061;
      `SEQ_DIG_FILTER: range_ok = ok_062;
      `SEQ_ALARM_HYST: range_ok = ok_063;
      default: range_ok = 1'b0;
    endcase
  end

  // Cause bits: [0] unknown sequence, [1] count, [2] digit or unit, [3] range;
  // an unknown sequence also fails range, as it has no legal values at all
  // Range is judged only on words that really are BCD
  wire block_ok = seq_ok && count_ok && unit_ok && bcd_ok && range_ok;
  wire [3:0] next_err_cause = {bcd_ok && !range_ok, !bcd_ok || !unit_ok,
                               !count_ok, !seq_ok};

  // Word for the current position: count, unit word, parameters
  // Positions past the block's end are never offered, so the default is safe
  wire [15:0] unit_word = {8'h00, unit};
  logic [15:0] next_word;
  always_comb begin
    case (pos)
      3'd0: next_word = count;
      3'd1: next_word = unit_word;
      3'd2: next_word = p0;
      3'd3: next_word = p1;
      default: next_word = p2;
    endcase
  end

  // Handshake on the device side
  // The far side may hold ready low for any time; the offer simply waits
  wire word_taken = blk_valid_out && blk_ready_in;
  wire block_sent = word_taken && blk_last_out;
  wire check_fail = (state == param_write_pkg::ST_CHECK) && !block_ok;

  // Next state of the formatter
  always_comb begin
    next_state = state;
    unique case (state)
      param_write_pkg::ST_IDLE: begin
        if (go) begin
          next_state = param_write_pkg::ST_CHECK;
        end
      end
      param_write_pkg::ST_CHECK: begin
        // A refused block never reaches the link
        if (block_ok) begin
          next_state = param_write_pkg::ST_SEND;
        end else begin
          next_state = param_write_pkg::ST_IDLE;
        end
      end
      param_write_pkg::ST_SEND: begin
        // No receive words follow, so the last send ends the job
        if (block_sent) begin
          next_state = param_write_pkg::ST_IDLE;
        end
      end
      default: next_state = param_write_pkg::ST_IDLE;
    endcase
  end

  // State register
  // Synchronous reset; an illegal code falls back to idle via the default
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= param_write_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Control word; settings frozen while a block is in flight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq <= `RST_SEQ;
      heat_cool <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      seq <= wr_data_in[`CTRL_SEQ_MSB:0];
      heat_cool <= wr_data_in[`CTRL_HEAT_COOL_BIT];
    end
  end

  // Count and unit words
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= `RST_COUNT;
      unit <= 8'h00;
    end else if (!busy) begin
      if (wr_count) begin
        count <= wr_data_in;
      end
      if (wr_unit) begin
        unit <= wr_data_in[7:0];
      end
    end
  end

  // Parameter words, one register each
  // The loop index fixes both the register and its offset on the port
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_param
      wire wr_this = wr_in && !busy && (addr_in == (`REG_PARAM0 + 4'(gi)));
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          param[gi] <= `RST_WORD;
        end else if (wr_this) begin
          param[gi] <= wr_data_in;
        end
      end
    end
  endgenerate

  // Word position and last position within the block
  // Reloaded at every check so a refused block leaves no stale offset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pos <= 3'd0;
      last_pos <= 3'd0;
    end else if (state == param_write_pkg::ST_CHECK) begin
      pos <= 3'd0;
      last_pos <= count[2:0] - 3'd1;
    end else if (word_taken) begin
      pos <= pos + 3'd1;
    end
  end

  // Outgoing word stream; held until the device takes it
  // Trade-off: the idle cycle after each word halves the peak rate, which
  // the slow serial link behind the device never notices
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      blk_valid_out <= 1'b0;
      blk_word_out <= `RST_WORD;
      blk_pos_out <= 3'd0;
      blk_last_out <= 1'b0;
      blk_seq_out <= `RST_SEQ;
    end else if (state == param_write_pkg::ST_CHECK && block_ok) begin
      blk_valid_out <= 1'b1;
      blk_word_out <= count;
      blk_pos_out <= 3'd0;
      blk_last_out <= 1'b0;
      blk_seq_out <= seq;
    end else if (block_sent) begin
      blk_valid_out <= 1'b0;
      blk_last_out <= 1'b0;
    end else if (state == param_write_pkg::ST_SEND && !blk_valid_out) begin
      blk_valid_out <= 1'b1;
      blk_word_out <= next_word;
      blk_pos_out <= pos;
      blk_last_out <= (pos == last_pos);
    end else if (word_taken) begin
      // Gap of one cycle between words keeps position logic simple
      blk_valid_out <= 1'b0;
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  // Busy mirrors the next state so it reads high from the go edge onwards
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status <= 3'b000;
    end else begin
      status[`ST_DONE_BIT] <= block_sent ||
        (status[`ST_DONE_BIT] && !(wr_status && wr_data_in[`ST_DONE_BIT]));
      status[`ST_ERROR_BIT] <= check_fail ||
        (status[`ST_ERROR_BIT] && !(wr_status && wr_data_in[`ST_ERROR_BIT]));
      status[`ST_BUSY_BIT] <= (next_state != param_write_pkg::ST_IDLE);
    end
  end

  // Error cause kept until the next check
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      err_cause <= 4'h0;
    end else if (state == param_write_pkg::ST_CHECK) begin
      err_cause <= block_ok ? 4'h0 : next_err_cause;
    end
  end

  // Interrupt mask
  // Mask writes stay open while busy; they never touch the block in flight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask <= 3'b000;
    end else if (wr_mask) begin
      mask <= wr_data_in[2:0];
    end
  end

  // Level interrupt, masked busy bit is not an event
  // One cycle of lag after a status change, since the output is registered
  wire [2:0] next_status_view = {1'b0, status[1:0]};
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_status_view & mask);
    end
  end

  // Read mux; unmapped offsets answer zero
  // The go bit is write-only and reads back as zero
  logic [15:0] rd_mux;
  always_comb begin
    case (addr_in)
      `REG_CTRL: rd_mux = {3'b000, heat_cool, seq};
      `REG_COUNT: rd_mux = count;
      `REG_UNIT: rd_mux = unit_word;
      `REG_PARAM0: rd_mux = p0;
      `REG_PARAM1: rd_mux = p1;
      `REG_PARAM2: rd_mux = p2;
      `REG_STATUS: rd_mux = {13'h0000, status};
      `REG_MASK: rd_mux = {13'h0000, mask};
      `REG_ERROR: rd_mux = {12'h000, err_cause};
      default: rd_mux = `RST_WORD;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside the answer cycle keeps a shared read bus quiet
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= `RST_WORD;
    end else if (rd_in) begin
      rd_data_out <= rd_mux;
    end else begin
      rd_data_out <= `RST_WORD;
    end
  end

endmodule : param_write_formatter

// ===== verilog/param_write_params.svh
`ifndef PARAM_WRITE_PARAMS_SVH
`define PARAM_WRITE_PARAMS_SVH

// Own register map, word index on the software port
`define REG_CTRL 4'h0
`define REG_COUNT 4'h1
`define REG_UNIT 4'h2
`define REG_PARAM0 4'h3
`define REG_PARAM1 4'h4
`define REG_PARAM2 4'h5
`define REG_STATUS 4'h6
`define REG_MASK 4'h7
`define REG_ERROR 4'h8

// Control word fields
`define CTRL_SEQ_MSB 11
`define CTRL_HEAT_COOL_BIT 12
`define CTRL_GO_BIT 15

// Status and mask bit positions
`define ST_DONE_BIT 0
`define ST_ERROR_BIT 1
`define ST_BUSY_BIT 2

// Error cause bit positions
`define ERR_SEQ_BIT 0
`define ERR_COUNT_BIT 1
`define ERR_BCD_BIT 2
`define ERR_RANGE_BIT 3

// Reset values
`define RST_WORD 16'h0000
`define RST_SEQ 12'h053
`define RST_COUNT 16'h0003

// Sequence numbers, three BCD digits
`define SEQ_COOL_COEF 12'h053
`define SEQ_DEAD_BAND 12'h054
`define SEQ_MAN_RESET 12'h055
`define SEQ_HYSTERESIS 12'h056
`define SEQ_CTRL_PERIOD 12'h057
`define SEQ_RAMP 12'h058
`define SEQ_LOOP_BREAK 12'h059
`define SEQ_MV_STOP_ERR 12'h060
`define SEQ_MV_LIMITS 12'h061
`define SEQ_DIG_FILTER 12'h062
`define SEQ_ALARM_HYST 12'h063

// Fixed word counts, four BCD digits
`define COUNT_ONE_PARAM 16'h0003
`define COUNT_TWO_PARAM 16'h0004
`define COUNT_THREE_PARAM 16'h0005

// Field limits, BCD coded so binary compare holds
`define LIM_MIN_ONE 16'h0001
`define LIM_MAX_ALL 16'h9999
`define LIM_MAX_1000 16'h1000
`define LIM_MAX_0099 16'h0099
`define LIM_MAX_1050 16'h1050
`define LIM_RAMP_HOURS 16'h0001
`define LIM_UNIT_MAX 8'h31

`endif

// ===== verilog/param_write_pkg.sv
package param_write_pkg;

  // Formatter sequencing states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_SEND = 2'b10
  } fmt_state_t;

  // Word position within an outgoing block
  typedef logic [2:0] word_pos_t;

endpackage : param_write_pkg
